// >>> dv/ccfg_master.sv
// Bus master model that clocks instruction frames into the device.
`timescale 1ns/10ps
module ccfg_master (
   input  wire  clk,
   input  wire  dout,
   input  wire  dout_oe,
   output logic sel,
   output logic sck,
   output logic din
);
   logic [15:0] rd_word;
   logic        oe_all;
   initial begin
      rd_word = 16'h0000;
      oe_all = 1'b0;
      sel = 1'b0;
      sck = 1'b0;
      din = 1'b0;
   end
   // Each phase lasts four core cycles, one more than the front end needs.
   task automatic frame(input logic [26:0] bits, input int n);
      sel = 1'b1;
      rd_word = 16'h0000;
      oe_all = 1'b1;
      for (int i = 0; i < n; i++) begin
         din = (i < 27) ? bits[26-i] : ~din;
         repeat (4) @(negedge clk);
         sck = 1'b1;
         repeat (4) @(negedge clk);
         // Output bits stand from a few core cycles after the rise until the next rise.
         if (i >= 11 && i < 27) begin
            rd_word = {rd_word[14:0], dout};
            oe_all = oe_all & dout_oe;
         end
         sck = 1'b0;
      end
      repeat (2) @(negedge clk);
      sel = 1'b0;
      din = ~din;
      repeat (24) @(negedge clk);
   endtask
endmodule

// >>> dv/ccfg_top_assertions.sv
// Port-level checks for the clock-count frame guard.
`timescale 1ns/10ps
module ccfg_chk #(
   parameter PROG_TIME = 500000
) (
   input wire CORE_CLK,
   input wire RESET_N,
   input wire SEL,
   input wire FRAME_ABORT,
   input wire PROG_BUSY
);
   reg [5:0]  low_r;
   reg [23:0] bcnt_r;
   // The low count saturates so that a stale abort long after a frame still fails.
   always @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         low_r <= 6'h3f;
         bcnt_r <= 24'h000000;
      end else begin
         low_r <= SEL ? 6'h00 : ((low_r == 6'h3f) ? low_r : low_r + 6'h01);
         bcnt_r <= PROG_BUSY ? bcnt_r + 24'h000001 : 24'h000000;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   sequence busy_begin;
      !PROG_BUSY ##1 PROG_BUSY;
   endsequence
   sequence sel_drop;
      SEL ##1 !SEL;
   endsequence
   a_abort_one_cycle: assert property (FRAME_ABORT |=> !FRAME_ABORT)
      else $error("abort pulse too long");
   a_abort_after_drop: assert property (FRAME_ABORT |-> low_r inside {[2:10]})
      else $error("abort not tied to select fall");
   a_busy_after_drop: assert property (busy_begin |-> low_r inside {[2:10]})
      else $error("busy not tied to select fall");
   a_busy_holds: assert property (busy_begin |=> PROG_BUSY [*8])
      else $error("busy dropped early");
   a_busy_length: assert property ($fell(PROG_BUSY) |->
      (bcnt_r >= PROG_TIME - 1 && bcnt_r <= PROG_TIME + 1))
      else $error("busy length wrong");
   a_quiet_busy: assert property (PROG_BUSY |-> !FRAME_ABORT)
      else $error("abort while busy");
   a_one_verdict: assert property (sel_drop ##[1:12] FRAME_ABORT |=> !FRAME_ABORT [*8])
      else $error("second abort for one frame");
endmodule
bind ccfg_top ccfg_chk #(.PROG_TIME(PROG_TIME)) chk_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
   .SEL(SEL), .FRAME_ABORT(FRAME_ABORT), .PROG_BUSY(PROG_BUSY));

// >>> dv/clock_count_frame_guard_test.sv
// Random and corner frames through the clock-count guard.
`timescale 1ns/10ps
`include "ccfg_defs.vh"
module clock_count_frame_guard_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic saw_ab;
   logic saw_bz;
   wire  sel, sck, din, abrt, busy, dout, dout_oe;
   logic [15:0] model [0:255];
   int   error_cnt = 0;
   int   checked = 0;
   initial forever #5 clk = ~clk;
   ccfg_top #(.PROG_TIME(80)) dut_u (.CORE_CLK(clk), .RESET_N(rst_n), .SEL(sel), .SER_CLK(sck),
      .SER_DIN(din), .SER_DOUT(dout), .SER_DOUT_OE(dout_oe), .FRAME_ABORT(abrt),
      .PROG_BUSY(busy));
   ccfg_master m_u (.clk(clk), .dout(dout), .dout_oe(dout_oe), .sel(sel), .sck(sck),
      .din(din));
   always @(posedge clk) begin
      if (abrt === 1'b1) saw_ab <= 1'b1;
      if (busy === 1'b1) saw_bz <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task results;
      if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic guarded(input logic [1:0] op, input logic [7:0] a);
      return op == `CCFG_OP_WRITE || op == `CCFG_OP_PAGE || (op == `CCFG_OP_EXT && a[7:6] != 2'h0);
   endfunction
   // A frame that starts while busy must raise no abort; its busy, read and model checks are skipped.
   task automatic run(input logic [1:0] op, input logic [7:0] a, input int n, input bit hold);
      logic        pre;
      logic [15:0] d;
      int          k;
      pre = (busy === 1'b1);
      d = 16'($urandom);
      saw_ab = 1'b0;
      saw_bz = 1'b0;
      m_u.frame({1'b1, op, a, d}, n);
      chk("frame_abort", guarded(op, a) && n != 27 && !pre, saw_ab);
      if (!pre)
         chk("prog_busy", guarded(op, a) && n == 27, saw_bz);
      if (!pre && op == `CCFG_OP_READ && n >= 27) begin
         chk_word("read_data", model[a], m_u.rd_word);
         chk("dout_oe", 1'b1, m_u.oe_all);
      end
      // The array model follows only frames that the guard lets through.
      if (!pre && guarded(op, a) && n == 27) begin
         if (op == `CCFG_OP_EXT && a[7:6] == `CCFG_EXT_FILL)
            foreach (model[j]) model[j] = d;
         else if (op != `CCFG_OP_EXT)
            model[a] = d;
      end
      for (k = 0; k < 200 && !hold && busy !== 1'b0; k++) @(negedge clk);
      if (k == 200) begin
         error_cnt++;
         results();
      end
   endtask
   initial begin
      void'($urandom(32'h3be8a003));
      foreach (model[j]) model[j] = `CCFG_ERASED_WORD;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      run(`CCFG_OP_WRITE, 8'h00, 27, 0);
      run(`CCFG_OP_WRITE, 8'hff, 28, 0);
      run(`CCFG_OP_WRITE, 8'h5a, 26, 0);
      run(`CCFG_OP_PAGE, 8'h03, 28, 0);
      for (int i = 1; i < 4; i++) run(`CCFG_OP_EXT, {i[1:0], 6'h00}, 29, 0);
      run(`CCFG_OP_EXT, 8'h00, 26, 0);
      run(`CCFG_OP_READ, 8'h10, 27, 0);
      run(`CCFG_OP_READ, 8'h00, 27, 0);
      run(`CCFG_OP_READ, 8'h5a, 27, 0);
      run(`CCFG_OP_WRITE, 8'h11, 27, 1);
      run(`CCFG_OP_WRITE, 8'h12, 3, 0);
      run(`CCFG_OP_READ, 8'h11, 27, 0);
      run(`CCFG_OP_EXT, 8'hc0, 27, 0);
      run(`CCFG_OP_READ, 8'hc0, 27, 0);
      run(`CCFG_OP_EXT, 8'h40, 27, 0);
      run(`CCFG_OP_READ, 8'h33, 27, 0);
      for (int i = 0; i < 30; i++)
         run(2'($urandom), 8'($urandom), ($urandom % 2) ? 27 : $urandom_range(40, 11), 0);
      results();
   end
endmodule

// >>> rtl/ccfg_defs.vh
// Constants for the clock-count frame guard.
`ifndef CCFG_DEFS_VH
`define CCFG_DEFS_VH
`define CCFG_OP_W           2
`define CCFG_ADDR_W         8
`define CCFG_DATA_W         16
`define CCFG_CNT_W          6
`define CCFG_WORD_FRAME     6'd27
`define CCFG_OP_READ        2'h2
`define CCFG_OP_WRITE       2'h1
`define CCFG_OP_EXT         2'h0
`define CCFG_OP_PAGE        2'h3
`define CCFG_EXT_FILL       2'h1
`define CCFG_EXT_PBW        2'h3
`define CCFG_EXT_PBC        2'h2
`define CCFG_ERASED_WORD    16'hffff
`define CCFG_MIN_DESELECT_NS 200
`define CCFG_CLK_PERIOD_NS  10
`define CCFG_PROG_CYCLES    24'd500000
`endif

// >>> rtl/ccfg_sync.v
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/10ps
module ccfg_sync #(
   parameter W = 3
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;
   // The first stage feeds only the second stage.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end
   assign q = sync_r;
endmodule

// >>> rtl/ccfg_top.v
// Serial EEPROM front end with a clock-pulse frame guard on write-type instructions.
// Summary of operation
// (RULE1) Count every serial clock pulse from start bit until select falls.
// (RULE2) Abort write-type instructions whose pulse count differs from the expected count; a fill or protection-bound frame cut inside its address is not aborted.
// (RULE3) Single-word write frame is 27 clocks: start, opcode, 8 address, 16 data.
// (RULE4) Master keeps select low at least 200 ns between frames.
// (RULE5) Every array word reads all ones before any programming.
// (RULE6) Select must fall before the clock edge after the last data bit.
// (RULE7) Serial data input is ignored during self-timed programming.
// (RULE8) Pulse counter restarts at one at every newly detected start bit.
`timescale 1ns/10ps
`include "ccfg_defs.vh"
module ccfg_top #(
   parameter ADDR_W     = `CCFG_ADDR_W,
   parameter DATA_W     = `CCFG_DATA_W,
   parameter PROG_TIME  = `CCFG_PROG_CYCLES
) (
   input  wire                CORE_CLK,
   input  wire                RESET_N,
   input  wire                SEL,
   input  wire                SER_CLK,
   input  wire                SER_DIN,
   output reg                 SER_DOUT,
   output reg                 SER_DOUT_OE,
   output reg                 FRAME_ABORT,
   output reg                 PROG_BUSY
);
   localparam DEPTH   = 1 << ADDR_W;
   localparam WORD_FR = 1 + `CCFG_OP_W + ADDR_W + DATA_W;
   localparam S_IDLE  = 3'd0;
   localparam S_OP    = 3'd1;
   localparam S_ADDR  = 3'd2;
   localparam S_DATA  = 3'd3;
   localparam S_READ  = 3'd4;
   localparam S_DONE  = 3'd5;
   localparam S_PROG  = 3'd6;
   // The load value is cut on purpose to the width of the programming timer.
   localparam [23:0] PROG_LOAD = PROG_TIME[23:0];

   ////////////////////////////////////////////////////////////////////////////
   // Reset enters at once but leaves through two flops, so all registers leave it together.
   reg        rst_meta_r;
   reg        rst_sync_r;
   always @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   wire       rst_n = rst_sync_r;

   // One synchroniser for all three pins keeps select, clock and data in step.
   wire [2:0] pins;
   ccfg_sync #(.W(3)) u_sync (
      .clk   (CORE_CLK),
      .rst_n (rst_n),
      .d     ({SEL, SER_CLK, SER_DIN}),
      .q     (pins)
   );
   wire       sel_s = pins[2];
   wire       clk_s = pins[1];
   wire       din_s = pins[0];
   reg        sel_d_r;
   reg        clk_d_r;
   // Both detectors reset to the idle low level of their pins, so no false edge follows reset.
   wire       rise  = clk_s & ~clk_d_r;
   wire       sel_fall = sel_d_r & ~sel_s;

   ////////////////////////////////////////////////////////////////////////////
   function is_guarded;
      input [1:0]        op;
      input [ADDR_W-1:0] adr;
      begin
         is_guarded = (op == `CCFG_OP_WRITE) || (op == `CCFG_OP_PAGE) ||
                      ((op == `CCFG_OP_EXT) &&
                       ((adr[ADDR_W-1:ADDR_W-2] == `CCFG_EXT_FILL) ||
                        (adr[ADDR_W-1:ADDR_W-2] == `CCFG_EXT_PBW) ||
                        (adr[ADDR_W-1:ADDR_W-2] == `CCFG_EXT_PBC)));
      end
   endfunction

   reg [2:0]          state_r;
   reg [`CCFG_CNT_W-1:0] cnt_r;
   reg [4:0]          bit_r;
   reg [1:0]          op_r;
   reg [ADDR_W-1:0]   adr_r;
   reg [DATA_W-1:0]   dat_r;
   reg [DATA_W-1:0]   rd_r;
   reg [23:0]         prog_r;
   reg [DATA_W-1:0]   mem [0:DEPTH-1];
   reg                prog_fill_r;

   ////////////////////////////////////////////////////////////////////////////
   // Memory as flip-flops; erased value is all ones, as shipped.
   integer i;
   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= `CCFG_ERASED_WORD; // [RULE5]
      end else if (state_r == S_PROG && prog_r == 24'd1) begin
         if (prog_fill_r) begin
            for (i = 0; i < DEPTH; i = i + 1)
               mem[i] <= dat_r;
         end else if (op_r != `CCFG_OP_EXT) begin
            // Protection-bound commands end here without touching the array.
            mem[adr_r] <= dat_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Only the write, page and fill paths touch the array here; protection-bound
   // commands are checked by the guard and then simply complete.
   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= S_IDLE;
         cnt_r       <= {`CCFG_CNT_W{1'b0}};
         bit_r       <= 5'd0;
         op_r        <= 2'h0;
         adr_r       <= {ADDR_W{1'b0}};
         dat_r       <= {DATA_W{1'b0}};
         rd_r        <= {DATA_W{1'b0}};
         prog_r      <= 24'd0;
         prog_fill_r <= 1'b0;
         sel_d_r     <= 1'b0;
         clk_d_r     <= 1'b0;
         SER_DOUT    <= 1'b0;
         SER_DOUT_OE <= 1'b0;
         FRAME_ABORT <= 1'b0;
         PROG_BUSY   <= 1'b0;
      end else begin
         sel_d_r     <= sel_s;
         clk_d_r     <= clk_s;
         FRAME_ABORT <= 1'b0;
         SER_DOUT_OE <= sel_s && (state_r == S_READ || state_r == S_PROG);
         // The count saturates instead of wrapping, so a glitch burst cannot alias to 27.
         if (state_r != S_IDLE && state_r != S_PROG && sel_s && rise &&
             cnt_r != {`CCFG_CNT_W{1'b1}})
            cnt_r <= cnt_r + 6'd1; // [RULE1]
         case (state_r)
            S_IDLE: begin
               if (sel_s && rise && din_s) begin
                  cnt_r   <= 6'd1; // [RULE8]
                  bit_r   <= 5'd0;
                  state_r <= S_OP;
               end
            end
            S_OP: begin
               if (!sel_s) state_r <= S_IDLE;
               else if (rise) begin
                  op_r  <= {op_r[0], din_s};
                  bit_r <= bit_r + 5'd1;
                  if (bit_r == 5'd1) begin
                     bit_r   <= 5'd0;
                     state_r <= S_ADDR;
                  end
               end
            end
            S_ADDR: begin
               if (!sel_s) begin
                  // A write cut short inside its address also has the wrong count.
                  FRAME_ABORT <= (op_r == `CCFG_OP_WRITE) ||
                                 (op_r == `CCFG_OP_PAGE); // [RULE2]
                  state_r     <= S_IDLE;
               end else if (rise) begin
                  adr_r <= {adr_r[ADDR_W-2:0], din_s};
                  bit_r <= bit_r + 5'd1;
                  if (bit_r == ADDR_W - 1) begin
                     bit_r   <= 5'd0;
                     state_r <= (op_r == `CCFG_OP_READ) ? S_READ : S_DATA;
                     rd_r    <= mem[{adr_r[ADDR_W-2:0], din_s}];
                  end
               end
            end
            S_DATA: begin
               if (rise && sel_s) begin
                  dat_r <= {dat_r[DATA_W-2:0], din_s};
                  bit_r <= bit_r + 5'd1;
               end
               if (sel_fall) begin
                  // A glitch adds pulses, so the frame length exposes it.
                  if (is_guarded(op_r, adr_r) && cnt_r != WORD_FR) begin // [RULE2] [RULE3]
                     FRAME_ABORT <= 1'b1;
                     state_r     <= S_IDLE;
                  end else if (is_guarded(op_r, adr_r) && bit_r == DATA_W) begin // [RULE6]
                     prog_fill_r <= (op_r == `CCFG_OP_EXT) &&
                                    (adr_r[ADDR_W-1:ADDR_W-2] == `CCFG_EXT_FILL);
                     prog_r      <= PROG_LOAD;
                     PROG_BUSY   <= 1'b1;
                     state_r     <= S_PROG;
                  end else
                     state_r <= S_IDLE;
               end
            end
            S_READ: begin
               if (!sel_s) state_r <= S_IDLE;
               else if (rise) begin
                  SER_DOUT <= rd_r[DATA_W-1];
                  rd_r     <= {rd_r[DATA_W-2:0], 1'b0};
               end
            end
            S_PROG: begin
               // Input data is dropped until the cycle ends. [RULE7]
               SER_DOUT <= 1'b0;
               prog_r   <= prog_r - 24'd1;
               if (prog_r == 24'd1) begin
                  PROG_BUSY <= 1'b0;
                  state_r   <= S_DONE;
               end
            end
            S_DONE: begin
               SER_DOUT <= 1'b1;
               state_r  <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule
